// file: dual_port_defs.svh
// Purpose : Shared constants for the dual-port counter and mailbox control logic
// Assumes : Included by its bare name from every design file
// Notes   : Offsets are byte addresses on the local register port
`ifndef DUAL_PORT_DEFS_SVH
`define DUAL_PORT_DEFS_SVH

// ----------------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------------
`define ADDR_W          18
`define DATA_W          36
`define BYTE_W          4
`define MEM_DEPTH       262144
`define MBOX_RIGHT      18'h3ffff
`define MBOX_LEFT       18'h3fffe

// ----------------------------------------------------------------------------
// Reset, clear, step and idle values
// ----------------------------------------------------------------------------
`define COUNT_RESET     18'h00000
`define MASK_RESET      18'h3ffff
`define MASK_CLEAR      18'h00000
`define COUNT_STEP      18'h00001
`define BYTES_IDLE      4'hf

// ----------------------------------------------------------------------------
// Register port
// ----------------------------------------------------------------------------
`define REG_AW          8
`define REG_DW          32
`define REG_STATUS      8'h00
`define REG_IRQ_MASK    8'h04
`define REG_PINS        8'h08
`define REG_COUNT_L     8'h0c
`define REG_COUNT_R     8'h10
`define REG_MASK_L      8'h14
`define REG_MASK_R      8'h18

// Event bit positions, shared by status, interrupt mask and pin readback
`define EV_W            4
`define EV_MBOX_L       0
`define EV_MBOX_R       1
`define EV_WRAP_L       2
`define EV_WRAP_R       3
`define EV_NONE         4'h0

`endif

// file: dual_port_pkg.sv
// Purpose : Types and small decode helpers for the dual-port control logic
// Assumes : dual_port_defs.svh holds every numeric constant
// Notes   : Nothing here holds state
`include "dual_port_defs.svh"

package dual_port_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`DATA_W-1:0] data_t;
  typedef logic [`BYTE_W-1:0] bytes_t;
  typedef logic [`EV_W-1:0]   events_t;

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------
  function automatic logic port_selected(input logic low_active, input logic high_active);
    port_selected = !low_active && high_active;
  endfunction : port_selected

  function automatic logic any_byte(input bytes_t byte_select_n);
    any_byte = (byte_select_n != `BYTES_IDLE);
  endfunction : any_byte

endpackage : dual_port_pkg

// file: port_counter.sv
// Purpose : Burst address counter with mask register and wrap flag for one port
// Assumes : Control inputs are synchronous to clk
// Notes   : Mask bits at one are the counting part; zero bits hold
`include "dual_port_defs.svh"

module port_counter (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire dual_port_pkg::addr_t addr,
  input  wire logic                 address_strobe_n,
  input  wire logic                 count_enable_n,
  input  wire logic                 counter_clear_n,
  input  wire logic                 mask_access_n,
  output dual_port_pkg::addr_t      count,
  output dual_port_pkg::addr_t      mask,
  output logic                      wrap_flag_n
);

  dual_port_pkg::addr_t next_count;
  dual_port_pkg::addr_t next_mask;
  dual_port_pkg::addr_t bumped;
  logic                 next_wrap_flag_n;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_count       = count;
    next_mask        = mask;
    next_wrap_flag_n = wrap_flag_n;
    // Carry out of the unmasked part is dropped, so the count wraps in place
    bumped = (count & ~mask) | ((count + `COUNT_STEP) & mask);
    if (mask_access_n) begin
      if (!counter_clear_n) begin
        next_count       = count & ~mask;
        next_wrap_flag_n = 1'b1;
      end else if (!address_strobe_n) begin
        next_count       = addr;
        next_wrap_flag_n = 1'b1;
      end else if (!count_enable_n) begin
        next_count       = bumped;
        next_wrap_flag_n = !((bumped & mask) == mask);
      end
    end else begin
      if (!counter_clear_n) begin
        next_mask = `MASK_CLEAR;
      end else if (!address_strobe_n) begin
        next_mask = addr;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      count       <= `COUNT_RESET;
      mask        <= `MASK_RESET;
      wrap_flag_n <= 1'b1;
    end else begin
      count       <= next_count;
      mask        <= next_mask;
      wrap_flag_n <= next_wrap_flag_n;
    end
  end

endmodule : port_counter

// file: mailbox_flags.sv
// Purpose : Mailbox interrupt flags of both ports
// Assumes : Set and clear requests are already qualified by the caller
// Notes   : A set in the same cycle as a clear keeps the flag asserted
`include "dual_port_defs.svh"

module mailbox_flags (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic set_left,
  input  wire logic clear_left,
  input  wire logic set_right,
  input  wire logic clear_right,
  output logic      mailbox_flag_n_l,
  output logic      mailbox_flag_n_r
);

  logic next_flag_n_l;
  logic next_flag_n_r;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_flag_n_l = mailbox_flag_n_l;
    next_flag_n_r = mailbox_flag_n_r;
    if (set_left) begin
      next_flag_n_l = 1'b0;
    end else if (clear_left) begin
      next_flag_n_l = 1'b1;
    end
    if (set_right) begin
      next_flag_n_r = 1'b0;
    end else if (clear_right) begin
      next_flag_n_r = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mailbox_flag_n_l <= 1'b1;
      mailbox_flag_n_r <= 1'b1;
    end else begin
      mailbox_flag_n_l <= next_flag_n_l;
      mailbox_flag_n_r <= next_flag_n_r;
    end
  end

endmodule : mailbox_flags

// file: dual_port_counter_mailbox.sv
// Purpose : Per-port control of a true dual-port memory with counters and mailboxes
// Assumes : Both ports and the register port share clk; rst is the master reset
// Notes   : Read data leave one cycle after the access; writes land at the edge
//
// The address-and-strobe port and the register addresses were decided locally.
`include "dual_port_defs.svh"

module dual_port_counter_mailbox (
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Left port
  input  wire dual_port_pkg::addr_t  addr_l,
  input  wire logic                  address_strobe_n_l,
  input  wire logic                  count_enable_n_l,
  input  wire logic                  counter_clear_n_l,
  input  wire logic                  mask_access_n_l,
  input  wire logic                  select_low_active_l,
  input  wire logic                  select_high_active_l,
  input  wire logic                  read_write_l,
  input  wire dual_port_pkg::bytes_t byte_select_n_l,
  input  wire logic                  output_drive_n_l,
  input  wire dual_port_pkg::data_t  dq_in_l,
  output dual_port_pkg::data_t       dq_out_l,
  output logic                       dq_oe_l,
  output logic                       mailbox_flag_n_l,
  output logic                       wrap_flag_n_l,
  // Right port
  input  wire dual_port_pkg::addr_t  addr_r,
  input  wire logic                  address_strobe_n_r,
  input  wire logic                  count_enable_n_r,
  input  wire logic                  counter_clear_n_r,
  input  wire logic                  mask_access_n_r,
  input  wire logic                  select_low_active_r,
  input  wire logic                  select_high_active_r,
  input  wire logic                  read_write_r,
  input  wire dual_port_pkg::bytes_t byte_select_n_r,
  input  wire logic                  output_drive_n_r,
  input  wire dual_port_pkg::data_t  dq_in_r,
  output dual_port_pkg::data_t       dq_out_r,
  output logic                       dq_oe_r,
  output logic                       mailbox_flag_n_r,
  output logic                       wrap_flag_n_r,
  // Register port
  input  wire logic [`REG_AW-1:0]    reg_addr,
  input  wire logic [`REG_DW-1:0]    reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [`REG_DW-1:0]         reg_rdata,
  output logic                       irq
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  // Contents survive rst
  dual_port_pkg::data_t    mem [0:`MEM_DEPTH-1];

  dual_port_pkg::addr_t    count_l;
  dual_port_pkg::addr_t    count_r;
  dual_port_pkg::addr_t    mask_l;
  dual_port_pkg::addr_t    mask_r;

  dual_port_pkg::addr_t    access_l;
  dual_port_pkg::addr_t    access_r;

  logic                    write_l;
  logic                    write_r;
  logic                    read_l;
  logic                    read_r;

  logic                    mbox_set_l;
  logic                    mbox_set_r;
  logic                    mbox_clear_l;
  logic                    mbox_clear_r;

  logic                    wrap_seen_n_l;
  logic                    wrap_seen_n_r;

  dual_port_pkg::data_t    next_dq_out_l;
  dual_port_pkg::data_t    next_dq_out_r;
  logic                    next_dq_oe_l;
  logic                    next_dq_oe_r;

  dual_port_pkg::events_t  status;
  dual_port_pkg::events_t  irq_mask;
  dual_port_pkg::events_t  events;
  dual_port_pkg::events_t  pins;

  dual_port_pkg::events_t  next_status;
  dual_port_pkg::events_t  next_irq_mask;
  logic                    next_irq;
  logic [`REG_DW-1:0]      next_reg_rdata;

  // --------------------------------------------------------------------------
  // Burst counters
  // --------------------------------------------------------------------------
  // One instance per port, so neither port's controls can touch the other
  port_counter counter_left (
    .clk              (clk),
    .rst              (rst),
    .addr             (addr_l),
    .address_strobe_n (address_strobe_n_l),
    .count_enable_n   (count_enable_n_l),
    .counter_clear_n  (counter_clear_n_l),
    .mask_access_n    (mask_access_n_l),
    .count            (count_l),
    .mask             (mask_l),
    .wrap_flag_n      (wrap_flag_n_l)
  );

  port_counter counter_right (
    .clk              (clk),
    .rst              (rst),
    .addr             (addr_r),
    .address_strobe_n (address_strobe_n_r),
    .count_enable_n   (count_enable_n_r),
    .counter_clear_n  (counter_clear_n_r),
    .mask_access_n    (mask_access_n_r),
    .count            (count_r),
    .mask             (mask_r),
    .wrap_flag_n      (wrap_flag_n_r)
  );

  // --------------------------------------------------------------------------
  // Access decode
  // --------------------------------------------------------------------------
  always_comb begin
    access_l = address_strobe_n_l ? count_l : addr_l;
    access_r = address_strobe_n_r ? count_r : addr_r;

    // A word access needs selection and at least one active byte lane
    write_l = dual_port_pkg::port_selected(select_low_active_l, select_high_active_l)
              && !read_write_l && dual_port_pkg::any_byte(byte_select_n_l);
    write_r = dual_port_pkg::port_selected(select_low_active_r, select_high_active_r)
              && !read_write_r && dual_port_pkg::any_byte(byte_select_n_r);
    read_l  = dual_port_pkg::port_selected(select_low_active_l, select_high_active_l)
              && read_write_l && dual_port_pkg::any_byte(byte_select_n_l);
    read_r  = dual_port_pkg::port_selected(select_low_active_r, select_high_active_r)
              && read_write_r && dual_port_pkg::any_byte(byte_select_n_r);

    // Only the cross write sets and only the owner's read clears
    mbox_set_l   = write_r && (access_r == `MBOX_LEFT);
    mbox_set_r   = write_l && (access_l == `MBOX_RIGHT);
    mbox_clear_l = read_l && (access_l == `MBOX_LEFT);
    mbox_clear_r = read_r && (access_r == `MBOX_RIGHT);
  end

  // --------------------------------------------------------------------------
  // Memory array
  // --------------------------------------------------------------------------
  // Same-address writes from both ports resolve right-port-last; hosts avoid it
  always_ff @(posedge clk) begin
    for (int b = 0; b < `BYTE_W; b++) begin
      if (write_l && !byte_select_n_l[b]) begin
        mem[access_l][b*9 +: 9] <= dq_in_l[b*9 +: 9];
      end
      if (write_r && !byte_select_n_r[b]) begin
        mem[access_r][b*9 +: 9] <= dq_in_r[b*9 +: 9];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read data and pin drive
  // --------------------------------------------------------------------------
  always_comb begin
    next_dq_out_l = read_l ? mem[access_l] : dq_out_l;
    next_dq_out_r = read_r ? mem[access_r] : dq_out_r;
    // Drive enable is sampled with the read, so it changes at the same edge as the read data
    next_dq_oe_l  = read_l && !output_drive_n_l;
    next_dq_oe_r  = read_r && !output_drive_n_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dq_out_l <= '0;
      dq_out_r <= '0;
      dq_oe_l  <= 1'b0;
      dq_oe_r  <= 1'b0;
    end else begin
      dq_out_l <= next_dq_out_l;
      dq_out_r <= next_dq_out_r;
      dq_oe_l  <= next_dq_oe_l;
      dq_oe_r  <= next_dq_oe_r;
    end
  end

  // --------------------------------------------------------------------------
  // Mailbox flags
  // --------------------------------------------------------------------------
  mailbox_flags mailboxes (
    .clk              (clk),
    .rst              (rst),
    .set_left         (mbox_set_l),
    .clear_left       (mbox_clear_l),
    .set_right        (mbox_set_r),
    .clear_right      (mbox_clear_r),
    .mailbox_flag_n_l (mailbox_flag_n_l),
    .mailbox_flag_n_r (mailbox_flag_n_r)
  );

  // --------------------------------------------------------------------------
  // Event capture
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      wrap_seen_n_l <= 1'b1;
      wrap_seen_n_r <= 1'b1;
    end else begin
      wrap_seen_n_l <= wrap_flag_n_l;
      wrap_seen_n_r <= wrap_flag_n_r;
    end
  end

  always_comb begin
    events             = `EV_NONE;
    events[`EV_MBOX_L] = mbox_set_l;
    events[`EV_MBOX_R] = mbox_set_r;
    events[`EV_WRAP_L] = wrap_seen_n_l && !wrap_flag_n_l;
    events[`EV_WRAP_R] = wrap_seen_n_r && !wrap_flag_n_r;

    pins               = `EV_NONE;
    pins[`EV_MBOX_L]   = mailbox_flag_n_l;
    pins[`EV_MBOX_R]   = mailbox_flag_n_r;
    pins[`EV_WRAP_L]   = wrap_flag_n_l;
    pins[`EV_WRAP_R]   = wrap_flag_n_r;
  end

  // --------------------------------------------------------------------------
  // Status, interrupt mask and interrupt
  // --------------------------------------------------------------------------
  always_comb begin
    next_status   = status;
    next_irq_mask = irq_mask;
    // Read clears, but an event in the same cycle survives the clear
    if (reg_rd && (reg_addr == `REG_STATUS)) begin
      next_status = `EV_NONE;
    end
    next_status = next_status | events;
    if (reg_wr && (reg_addr == `REG_IRQ_MASK)) begin
      next_irq_mask = reg_wdata[`EV_W-1:0];
    end
    next_irq = |(next_status & next_irq_mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status   <= `EV_NONE;
      irq_mask <= `EV_NONE;
      irq      <= 1'b0;
    end else begin
      status   <= next_status;
      irq_mask <= next_irq_mask;
      irq      <= next_irq;
    end
  end

  // --------------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------------
  always_comb begin
    next_reg_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `REG_STATUS:   next_reg_rdata = {{(`REG_DW-`EV_W){1'b0}}, status};
        `REG_IRQ_MASK: next_reg_rdata = {{(`REG_DW-`EV_W){1'b0}}, irq_mask};
        `REG_PINS:     next_reg_rdata = {{(`REG_DW-`EV_W){1'b0}}, pins};
        `REG_COUNT_L:  next_reg_rdata = {{(`REG_DW-`ADDR_W){1'b0}}, count_l};
        `REG_COUNT_R:  next_reg_rdata = {{(`REG_DW-`ADDR_W){1'b0}}, count_r};
        `REG_MASK_L:   next_reg_rdata = {{(`REG_DW-`ADDR_W){1'b0}}, mask_l};
        `REG_MASK_R:   next_reg_rdata = {{(`REG_DW-`ADDR_W){1'b0}}, mask_r};
        default:       next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule : dual_port_counter_mailbox

// file: dual_port_counter_mailbox_properties.sv
// Purpose: Port-level properties of dual_port_counter_mailbox
// Assumes: One clock, rst synchronous and active high
// Notes  : Counter contents are judged by the bench through register reads
`include "dual_port_defs.svh"

module dual_port_counter_mailbox_properties (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire dual_port_pkg::addr_t  addr_l,
  input wire logic                  address_strobe_n_l,
  input wire logic                  count_enable_n_l,
  input wire logic                  counter_clear_n_l,
  input wire logic                  mask_access_n_l,
  input wire logic                  select_low_active_l,
  input wire logic                  select_high_active_l,
  input wire logic                  read_write_l,
  input wire dual_port_pkg::bytes_t byte_select_n_l,
  input wire logic                  output_drive_n_l,
  input wire logic                  dq_oe_l,
  input wire logic                  mailbox_flag_n_l,
  input wire logic                  wrap_flag_n_l,
  input wire logic                  select_low_active_r,
  input wire logic                  select_high_active_r,
  input wire logic                  mailbox_flag_n_r
);
  timeunit 1ns;
  timeprecision 1ps;
  wire sel_l = !select_low_active_l && select_high_active_l;
  wire sel_r = !select_low_active_r && select_high_active_r;
  // Only strobed writes: counter-addressed ones would need the hidden count
  wire wr_l = sel_l && !address_strobe_n_l && !read_write_l && byte_select_n_l != `BYTES_IDLE;
  wire idle_l = count_enable_n_l && address_strobe_n_l && counter_clear_n_l;
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  property p_load; mask_access_n_l && counter_clear_n_l && !address_strobe_n_l |=> wrap_flag_n_l;
  endproperty
  a_load: assert property (p_load) else $error("wrap flag low after load");
  property p_clear; mask_access_n_l && !counter_clear_n_l |=> wrap_flag_n_l; endproperty
  a_clear: assert property (p_clear) else $error("wrap flag low after clear");
  property p_hold; !wrap_flag_n_l && mask_access_n_l && idle_l |=> !wrap_flag_n_l; endproperty
  a_hold: assert property (p_hold) else $error("wrap flag released while idle");
  property p_set_r; wr_l && addr_l == `MBOX_RIGHT |=> !mailbox_flag_n_r; endproperty
  a_set_r: assert property (p_set_r) else $error("right mailbox flag not set");
  property p_own; wr_l && addr_l == `MBOX_LEFT && !sel_r |=> $stable(mailbox_flag_n_l); endproperty
  a_own: assert property (p_own) else $error("own mailbox write moved flag");
  property p_bytes;
    sel_l && !read_write_l && byte_select_n_l == `BYTES_IDLE && !sel_r
      |=> $stable(mailbox_flag_n_r);
  endproperty
  a_bytes: assert property (p_bytes) else $error("idle bytes moved mailbox flag");
  property p_desel; !sel_l |=> !dq_oe_l; endproperty
  a_desel: assert property (p_desel) else $error("drive while deselected");
  property p_oe; output_drive_n_l |=> !dq_oe_l; endproperty
  a_oe: assert property (p_oe) else $error("drive without output enable");
endmodule : dual_port_counter_mailbox_properties

bind dual_port_counter_mailbox dual_port_counter_mailbox_properties
  dual_port_counter_mailbox_properties_inst (.clk, .rst, .addr_l, .address_strobe_n_l,
  .count_enable_n_l, .counter_clear_n_l, .mask_access_n_l, .select_low_active_l,
  .select_high_active_l, .read_write_l, .byte_select_n_l, .output_drive_n_l, .dq_oe_l,
  .mailbox_flag_n_l, .wrap_flag_n_l, .select_low_active_r, .select_high_active_r,
  .mailbox_flag_n_r);

// file: dual_port_host.sv
// Purpose: Host logic model for one port of the dual-port block
// Assumes: Bench calls op once per access, accesses never overlap
// Notes  : Released address and data lines carry the inverse of their last value; controls go idle
module dual_port_host (
  input  wire logic                 clk,
  input  wire dual_port_pkg::data_t dq_out,
  input  wire logic                 dq_oe,
  output dual_port_pkg::addr_t      addr,
  output logic [4:0]                ctl_n,
  output logic                      sel_n,
  output logic                      sel_hi,
  output logic                      rw,
  output dual_port_pkg::bytes_t     be_n,
  output dual_port_pkg::data_t      dq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ctl_n: strobe, count enable, clear, mask access, output drive
  initial {addr, ctl_n, sel_n, sel_hi, rw, be_n, dq} = {18'h0, 5'h1f, 3'h5, 4'hf, 36'h0};
  // Serial calls keep both hosts off one address in one cycle
  task automatic op(input dual_port_pkg::addr_t a, input logic [4:0] c, input logic [1:0] s,
                    input logic r, input dual_port_pkg::bytes_t b, output dual_port_pkg::data_t q,
                    output logic oe);
    @(posedge clk);
    {addr, ctl_n, sel_n, sel_hi, rw, be_n, dq} <= {a, c, s, r, b, a, a};
    @(posedge clk);
    {addr, ctl_n, sel_n, sel_hi, be_n, dq} <= {~a, 5'h1f, 2'b10, 4'hf, ~a, ~a};
    // The pin shows the device word only while driven, else our own level
    #1 q = dq_oe ? dq_out : dq;
    oe = dq_oe;
  endtask : op
endmodule : dual_port_host

// file: dual_port_counter_mailbox_tb_top.sv
// Purpose: Self-checking bench for dual_port_counter_mailbox
// Assumes: Hosts and register port share clk
// Notes  : Written word of an access is its address twice
`include "dual_port_defs.svh"

module dual_port_counter_mailbox_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] LD = 5'h0e, INC = 5'h16, LDINC = 5'h06, CLRALL = 5'h02, CLR = 5'h1a;
  localparam logic [4:0] MLD = 5'h0c, MINC = 5'h14, MCLR = 5'h18, NOOE = 5'h0f;
  localparam logic [1:0] SEL = 2'b01;
  logic                  clk = 1'b0;
  logic                  rst, reg_wr, reg_rd, irq, oe;
  logic [7:0]            reg_addr;
  logic [31:0]           reg_wdata, reg_rdata;
  dual_port_pkg::addr_t  addr_l, addr_r;
  dual_port_pkg::data_t  dq_l, dq_r, dq_out_l, dq_out_r, q;
  dual_port_pkg::bytes_t be_l, be_r;
  logic [4:0]            ctl_l, ctl_r;
  logic                  sel_n_l, sel_n_r, sel_hi_l, sel_hi_r, rw_l, rw_r, dq_oe_l, dq_oe_r;
  logic                  mailbox_flag_n_l, mailbox_flag_n_r, wrap_flag_n_l, wrap_flag_n_r;
  int                    errors = 0;
  int                    checks_done = 0;

  dual_port_host dual_port_host_inst_l (.clk, .dq_out(dq_out_l), .dq_oe(dq_oe_l), .addr(addr_l),
    .ctl_n(ctl_l), .sel_n(sel_n_l), .sel_hi(sel_hi_l), .rw(rw_l), .be_n(be_l), .dq(dq_l));
  dual_port_host dual_port_host_inst_r (.clk, .dq_out(dq_out_r), .dq_oe(dq_oe_r), .addr(addr_r),
    .ctl_n(ctl_r), .sel_n(sel_n_r), .sel_hi(sel_hi_r), .rw(rw_r), .be_n(be_r), .dq(dq_r));
  dual_port_counter_mailbox dual_port_counter_mailbox_inst (.clk, .rst, .addr_l,
    .address_strobe_n_l(ctl_l[4]), .count_enable_n_l(ctl_l[3]), .counter_clear_n_l(ctl_l[2]),
    .mask_access_n_l(ctl_l[1]), .select_low_active_l(sel_n_l), .select_high_active_l(sel_hi_l),
    .read_write_l(rw_l), .byte_select_n_l(be_l), .output_drive_n_l(ctl_l[0]), .dq_in_l(dq_l),
    .dq_out_l, .dq_oe_l, .mailbox_flag_n_l, .wrap_flag_n_l, .addr_r,
    .address_strobe_n_r(ctl_r[4]), .count_enable_n_r(ctl_r[3]), .counter_clear_n_r(ctl_r[2]),
    .mask_access_n_r(ctl_r[1]), .select_low_active_r(sel_n_r), .select_high_active_r(sel_hi_r),
    .read_write_r(rw_r), .byte_select_n_r(be_r), .output_drive_n_r(ctl_r[0]), .dq_in_r(dq_r),
    .dq_out_r, .dq_oe_r, .mailbox_flag_n_r, .wrap_flag_n_r, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq);

  always #20 clk = ~clk;

  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, reg_rdata);
  endtask : rd_reg
  task automatic acc(input logic rs, input logic [17:0] a, input logic [4:0] c,
                     input logic [1:0] s, input logic r, input logic [3:0] b);
    if (rs) dual_port_host_inst_r.op(a, c, s, r, b, q, oe);
    else dual_port_host_inst_l.op(a, c, s, r, b, q, oe);
  endtask : acc
  task automatic cnt(input logic [4:0] c, input logic [17:0] a);
    acc(1'b0, a, c, 2'b10, 1'b1, 4'hf);
  endtask : cnt
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    test_done();
  end

  initial begin
    {rst, reg_addr, reg_wdata, reg_wr, reg_rd} = {1'b1, 42'h0};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`REG_COUNT_L, 32'h0);
    rd_reg(`REG_MASK_R, 32'h3ffff);
    rd_reg(`REG_PINS, 32'hf);
    $display("test reset done");
    cnt(LD, 18'h3fffc);
    repeat (2) cnt(INC, 18'h0);
    rd_reg(`REG_COUNT_L, 32'h3fffe);
    cnt(INC, 18'h0);
    chk("wrap", 1'b0, wrap_flag_n_l);
    cnt(LDINC, 18'h00100);
    rd_reg(`REG_COUNT_L, 32'h100);
    cnt(CLRALL, 18'h00200);
    rd_reg(`REG_COUNT_L, 32'h0);
    rd_reg(`REG_STATUS, 32'h4);
    $display("test counter done");
    cnt(MLD, 18'h0000f);
    cnt(MINC, 18'h0);
    rd_reg(`REG_MASK_L, 32'hf);
    rd_reg(`REG_COUNT_L, 32'h0);
    cnt(LD, 18'h12345);
    cnt(CLR, 18'h0);
    rd_reg(`REG_COUNT_L, 32'h12340);
    repeat (15) cnt(INC, 18'h0);
    chk("wrap", 1'b0, wrap_flag_n_l);
    cnt(INC, 18'h0);
    rd_reg(`REG_COUNT_L, 32'h12340);
    cnt(MCLR, 18'h0);
    rd_reg(`REG_MASK_L, 32'h0);
    rd_reg(`REG_MASK_R, 32'h3ffff);
    $display("test mask done");
    wr_reg(`REG_IRQ_MASK, 32'h3);
    rd_reg(`REG_STATUS, 32'h4);
    acc(1'b0, `MBOX_RIGHT, LD, SEL, 1'b0, 4'h0);
    acc(1'b0, `MBOX_RIGHT, LD, SEL, 1'b1, 4'h0);
    chk("data", {`MBOX_RIGHT, `MBOX_RIGHT}, q);
    rd_reg(`REG_PINS, 32'hd);
    chk("irq", 1'b1, irq);
    acc(1'b1, `MBOX_RIGHT, LD, SEL, 1'b1, 4'h0);
    chk("oe", 1'b1, oe);
    chk("data r", {`MBOX_RIGHT, `MBOX_RIGHT}, q);
    rd_reg(`REG_PINS, 32'hf);
    rd_reg(`REG_STATUS, 32'h2);
    acc(1'b1, `MBOX_RIGHT, LD, SEL, 1'b0, 4'h0);
    for (int i = 0; i < 4; i++) acc(1'b0, `MBOX_RIGHT, LD, i[1:0]^SEL, 1'b0, {4{i==0}});
    chk("flag r", 1'b1, mailbox_flag_n_r);
    acc(1'b0, `MBOX_LEFT, LD, SEL, 1'b0, 4'h0);
    chk("flag l", 1'b1, mailbox_flag_n_l);
    acc(1'b1, `MBOX_LEFT, LD, SEL, 1'b0, 4'he);
    chk("flag l", 1'b0, mailbox_flag_n_l);
    rd_reg(`REG_COUNT_R, 32'h3fffe);
    acc(1'b0, `MBOX_LEFT, NOOE, SEL, 1'b1, 4'h0);
    chk("oe", 1'b0, oe);
    chk("flag l", 1'b1, mailbox_flag_n_l);
    rd_reg(`REG_STATUS, 32'h1);
    rd_reg(8'hfc, 32'h0);
    chk("irq", 1'b0, irq);
    $display("test mailbox done");
    test_done();
  end
endmodule : dual_port_counter_mailbox_tb_top
